// ---- rtl/dcc_defines.svh ----
// Offsets, field positions, reset values and timing figures of the core control block
`ifndef DCC_DEFINES_SVH
`define DCC_DEFINES_SVH

// Control port locations
`define DCC_LOC_CORE_CTRL  12'h81C
`define DCC_LOC_IF_FIRST   12'h800
`define DCC_LOC_IF_LAST    12'h807
`define DCC_LOC_AUX_FIRST  12'h809
`define DCC_LOC_AUX_LAST   12'h80C
`define DCC_LOC_SL_DATA    12'h810
`define DCC_LOC_SL_ADDR    12'h815

// Core control field positions
`define DCC_B_RATE_LO      0
`define DCC_B_RATE_HI      1
`define DCC_B_CORE_RUN     2
`define DCC_B_OUT_UNMUTE   3
`define DCC_B_IN_UNMUTE    4
`define DCC_B_SL_TRIG      5
`define DCC_B_IF_HW        6
`define DCC_B_PIN_HW       7
`define DCC_B_AUX_HW       8
`define DCC_B_DEB_LO       12
`define DCC_B_DEB_HI       13

// Reset value and writable bits of core control
`define DCC_CORE_CTRL_RST  16'h0000
`define DCC_CORE_CTRL_WMSK 16'h31FF

// Debounce times in ms, clock rate in kHz
`define DCC_DEB_T00_MS     20
`define DCC_DEB_T01_MS     40
`define DCC_DEB_T10_MS     10
`define DCC_DEB_T11_MS     5
`define DCC_CLK_KHZ        250000

// Instructions per sample at each rate
`define DCC_INSTR_1X       11'h400
`define DCC_INSTR_2X       11'h200
`define DCC_INSTR_4X       11'h100

// Number of safeload pairs
`define DCC_SL_PAIRS       5

`endif

// ---- rtl/dcc_pkg.sv ----
// Types shared by the core control block
package dcc_pkg;

   // Rate select codes
   typedef enum logic [1:0] {
      DCC_RATE_1X   = 2'b00,
      DCC_RATE_2X   = 2'b01,
      DCC_RATE_4X   = 2'b10,
      DCC_RATE_RSVD = 2'b11
   } dcc_rate_type;

   // Safeload engine states, Gray along idle, scan, done
   typedef enum logic [1:0] {
      DCC_SL_IDLE = 2'b00,
      DCC_SL_SCAN = 2'b01,
      DCC_SL_DONE = 2'b11
   } dcc_sl_state_type;

endpackage

// ---- rtl/dcc_sl_if.sv ----
// Carrier between the control register file and the safeload engine
`timescale 1ns/1ns
`default_nettype none
interface dcc_sl_if #(
   parameter int PA_W = 10,
   parameter int PD_W = 32
);
   logic            wr_en;    // Pair register write
   logic            wr_addr;  // High: address half, low: data half
   logic [2:0]      wr_idx;   // Pair index
   logic [PD_W-1:0] wr_val;   // Write value
   logic            start;    // Transfer request pulse
   logic            done;     // Transfer finished pulse
   logic            pm_we;    // Parameter memory write strobe
   logic [PA_W-1:0] pm_addr;  // Parameter memory address
   logic [PD_W-1:0] pm_data;  // Parameter memory data

   modport ctl (output wr_en, wr_addr, wr_idx, wr_val, start,
                input done, pm_we, pm_addr, pm_data);
   modport eng (input wr_en, wr_addr, wr_idx, wr_val, start,
                output done, pm_we, pm_addr, pm_data);
endinterface
`default_nettype wire

// ---- rtl/dcc_safeload.sv ----
// Safeload engine: five address/data pairs copied into parameter memory
`timescale 1ns/1ns
`default_nettype none
`include "dcc_defines.svh"
module dcc_safeload
   import dcc_pkg::*;
#(
   parameter int PA_W = 10,
   parameter int PD_W = 32
) (
   input  wire logic sys_clk,
   input  wire logic rst,
   dcc_sl_if.eng     sl
);
   localparam int NP = `DCC_SL_PAIRS;

   ////////////////////////////////////////////////////////////////////////
   // State
   logic [PA_W-1:0]  addr_r [NP];       // Address halves
   logic [PD_W-1:0]  data_r [NP];       // Data halves
   logic [NP-1:0]    pend_r, pend_nxt;  // Pairs written since last transfer
   logic [2:0]       idx_r, idx_nxt;    // Scan position
   dcc_sl_state_type st_r, st_nxt;      // Engine state
   logic             we_r, we_nxt;
   logic [PA_W-1:0]  pa_r, pa_nxt;
   logic [PD_W-1:0]  pd_r, pd_nxt;
   logic             done_r, done_nxt;

   ////////////////////////////////////////////////////////////////////////
   // Pair storage, one slot per index
   for (genvar i = 0; i < NP; i++) begin : g_pair
      always_ff @(posedge sys_clk) begin
         if (rst) begin
            addr_r[i] <= '0;
            data_r[i] <= '0;
         end else if (sl.wr_en && sl.wr_idx == 3'(i)) begin
            if (sl.wr_addr) begin
               addr_r[i] <= sl.wr_val[PA_W-1:0];
            end else begin
               data_r[i] <= sl.wr_val;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sequencer next state
   always_comb begin
      pend_nxt = pend_r;
      idx_nxt  = idx_r;
      st_nxt   = st_r;
      we_nxt   = 1'b0;
      pa_nxt   = pa_r;
      pd_nxt   = pd_r;
      done_nxt = 1'b0;
      case (st_r)
         DCC_SL_IDLE: begin
            // Start from the first pair
            if (sl.start) begin
               st_nxt  = DCC_SL_SCAN;
               idx_nxt = 3'h0;
            end
         end
         DCC_SL_SCAN: begin
            // Only pending pairs reach memory; see R7
            if (pend_r[idx_r]) begin
               we_nxt          = 1'b1;
               pa_nxt          = addr_r[idx_r];
               pd_nxt          = data_r[idx_r];
               pend_nxt[idx_r] = 1'b0;
            end
            if (idx_r == 3'(NP - 1)) begin
               st_nxt = DCC_SL_DONE;
            end else begin
               idx_nxt = idx_r + 3'h1;
            end
         end
         DCC_SL_DONE: begin
            // Tell the register file to drop the trigger; see R6
            done_nxt = 1'b1;
            st_nxt   = DCC_SL_IDLE;
         end
         default: begin
            st_nxt = DCC_SL_IDLE;
         end
      endcase
      // A fresh write marks its pair even while it is being copied
      if (sl.wr_en && sl.wr_idx < 3'(NP)) begin
         pend_nxt[sl.wr_idx] = 1'b1; // see R7
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sequencer registers
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pend_r <= '0;
         idx_r  <= 3'h0;
         st_r   <= DCC_SL_IDLE;
         we_r   <= 1'b0;
         pa_r   <= '0;
         pd_r   <= '0;
         done_r <= 1'b0;
      end else begin
         pend_r <= pend_nxt;
         idx_r  <= idx_nxt;
         st_r   <= st_nxt;
         we_r   <= we_nxt;
         pa_r   <= pa_nxt;
         pd_r   <= pd_nxt;
         done_r <= done_nxt;
      end
   end

   assign sl.pm_we   = we_r;
   assign sl.pm_addr = pa_r;
   assign sl.pm_data = pd_r;
   assign sl.done    = done_r;
endmodule
`default_nettype wire

// ---- rtl/dcc_core_ctrl.sv ----
// Core control register, interface and auxiliary registers, pin debounce
`timescale 1ns/1ns
`default_nettype none
`include "dcc_defines.svh"
//
// Contract
// R1: Debounce field picks 20/40/10/5 ms.
// R2: Aux host-write bit allows port aux writes.
// R3: Aux host-write bit makes aux ignore pins.
// R4: Interface host-write bit allows port interface writes.
// R5: Interface host-write bit blocks program interface writes.
// R6: Trigger write starts transfer, self-clears after.
// R7: Five pairs; only freshly written ones copied.
// R8: Input unmute resets 0, low mutes.
// R9: Output unmute resets 0, low mutes.
// R10: Core run resets 0, low clears core.
// R11: Single rate gives 1024 instructions.
// R12: Double rate gives 512 instructions, 96k.
// R13: Quadruple rate gives 256 instructions, 192k.
// R14: Host never writes reserved rate code.
module dcc_core_ctrl
   import dcc_pkg::*;
#(
   parameter int NGPIO   = 4,
   parameter int REG_W   = 32,
   parameter int PA_W    = 10,
   parameter int DEB_W   = 24,
   parameter int DEB_C00 = `DCC_DEB_T00_MS * `DCC_CLK_KHZ,
   parameter int DEB_C01 = `DCC_DEB_T01_MS * `DCC_CLK_KHZ,
   parameter int DEB_C10 = `DCC_DEB_T10_MS * `DCC_CLK_KHZ,
   parameter int DEB_C11 = `DCC_DEB_T11_MS * `DCC_CLK_KHZ
) (
   input  wire logic               sys_clk,
   input  wire logic               rst,
   input  wire logic               ctl_wr,
   input  wire logic               ctl_rd,
   input  wire logic [11:0]        ctl_addr,
   input  wire logic [REG_W-1:0]   ctl_wdata,
   output var  logic [REG_W-1:0]   ctl_rdata,
   input  wire logic               prog_if_we,
   input  wire logic [2:0]         prog_if_idx,
   input  wire logic [REG_W-1:0]   prog_if_data,
   input  wire logic               aux_pin_we,
   input  wire logic [1:0]         aux_pin_idx,
   input  wire logic [REG_W-1:0]   aux_pin_data,
   output var  logic [8*REG_W-1:0] iface_regs,
   output var  logic [4*REG_W-1:0] aux_regs,
   input  wire logic [NGPIO-1:0]   gpio_in,
   output var  logic [NGPIO-1:0]   gpio_deb,
   output var  logic               pin_reg_host_write,
   output var  logic               input_mute,
   output var  logic               output_mute,
   output var  logic               core_clear,
   output var  logic [1:0]         rate_select,
   output var  logic [10:0]        instr_per_sample,
   output var  logic               pm_we,
   output var  logic [PA_W-1:0]    pm_addr,
   output var  logic [REG_W-1:0]   pm_data
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [15:0]      cc_r, cc_nxt;          // Core control word
   logic [REG_W-1:0] if_r  [8];             // Interface registers
   logic [REG_W-1:0] if_nxt[8];
   logic [REG_W-1:0] ax_r  [4];             // Auxiliary converter results
   logic [REG_W-1:0] ax_nxt[4];
   logic [REG_W-1:0] rd_r, rd_nxt;          // Read data holding
   logic [10:0]      ips_r, ips_nxt;        // Instructions per sample
   logic [DEB_W-1:0] deb_lim;               // Debounce length in cycles
   logic             wr_cc, wr_if, wr_ax;   // Port write decodes
   logic [2:0]       if_idx;
   logic [1:0]       ax_idx;
   logic [11:0]      sl_off;

   dcc_sl_if #(.PA_W(PA_W), .PD_W(REG_W)) sl ();

   ////////////////////////////////////////////////////////////////////////
   // Address decode of port writes
   always_comb begin
      wr_cc  = 1'b0;
      wr_if  = 1'b0;
      wr_ax  = 1'b0;
      if_idx = ctl_addr[2:0];
      ax_idx = 2'(ctl_addr - `DCC_LOC_AUX_FIRST);
      sl_off = 12'h000;
      sl.wr_en   = 1'b0;
      sl.wr_addr = 1'b0;
      sl.wr_idx  = 3'h0;
      sl.wr_val  = ctl_wdata;
      if (!ctl_wr) begin
         // Idle port
      end else if (ctl_addr == `DCC_LOC_CORE_CTRL) begin
         wr_cc = 1'b1;
      end else if (ctl_addr >= `DCC_LOC_IF_FIRST &&
                   ctl_addr <= `DCC_LOC_IF_LAST) begin
         // Port reaches interface registers only in host mode; see R4
         wr_if = cc_r[`DCC_B_IF_HW];
      end else if (ctl_addr >= `DCC_LOC_AUX_FIRST &&
                   ctl_addr <= `DCC_LOC_AUX_LAST) begin
         // Port reaches aux registers only in host mode; see R2
         wr_ax = cc_r[`DCC_B_AUX_HW];
      end else if (ctl_addr >= `DCC_LOC_SL_DATA &&
                   ctl_addr < `DCC_LOC_SL_ADDR) begin
         sl_off    = ctl_addr - `DCC_LOC_SL_DATA;
         sl.wr_en  = 1'b1;
         sl.wr_idx = sl_off[2:0];
      end else if (ctl_addr >= `DCC_LOC_SL_ADDR &&
                   ctl_addr < `DCC_LOC_SL_ADDR + 12'h005) begin
         sl_off     = ctl_addr - `DCC_LOC_SL_ADDR;
         sl.wr_en   = 1'b1;
         sl.wr_addr = 1'b1;
         sl.wr_idx  = sl_off[2:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Core control next value
   always_comb begin
      cc_nxt   = cc_r;
      sl.start = 1'b0;
      if (sl.done) begin
         cc_nxt[`DCC_B_SL_TRIG] = 1'b0;  // see R6
      end
      if (wr_cc) begin
         // Trigger bit only sets; a write of 0 leaves a running transfer
         cc_nxt = (ctl_wdata[15:0] & `DCC_CORE_CTRL_WMSK) |
                  {10'h000, cc_nxt[`DCC_B_SL_TRIG], 5'h00};
         // Starts when idle or as the last transfer ends; a set that meets
         // done must restart, or the bit would stay up with nothing running
         if (ctl_wdata[`DCC_B_SL_TRIG] &&
             (!cc_r[`DCC_B_SL_TRIG] || sl.done)) begin
            sl.start = 1'b1;  // see R6
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interface and aux register next values
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if_nxt[i] = if_r[i];
      end
      for (int i = 0; i < 4; i++) begin
         ax_nxt[i] = ax_r[i];
      end
      // Program updates are dropped in host mode; see R5
      if (prog_if_we && !cc_r[`DCC_B_IF_HW]) begin
         if_nxt[prog_if_idx] = prog_if_data;
      end
      if (wr_if) begin
         if_nxt[if_idx] = ctl_wdata;  // see R4
      end
      // Pin-derived values are dropped in host mode; see R3
      if (aux_pin_we && !cc_r[`DCC_B_AUX_HW]) begin
         ax_nxt[aux_pin_idx] = aux_pin_data;
      end
      if (wr_ax) begin
         ax_nxt[ax_idx] = ctl_wdata;  // see R2
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read mux and rate decode
   always_comb begin
      rd_nxt = '0;
      if (!ctl_rd) begin
         rd_nxt = rd_r;
      end else if (ctl_addr == `DCC_LOC_CORE_CTRL) begin
         rd_nxt = REG_W'(cc_r);
      end else if (ctl_addr >= `DCC_LOC_IF_FIRST &&
                   ctl_addr <= `DCC_LOC_IF_LAST) begin
         rd_nxt = if_r[ctl_addr[2:0]];
      end else if (ctl_addr >= `DCC_LOC_AUX_FIRST &&
                   ctl_addr <= `DCC_LOC_AUX_LAST) begin
         rd_nxt = ax_r[ax_idx];
      end
      // Reserved code falls back to single rate, host must avoid it
      case (dcc_rate_type'(cc_r[`DCC_B_RATE_HI:`DCC_B_RATE_LO]))
         DCC_RATE_2X: ips_nxt = `DCC_INSTR_2X;  // see R12
         DCC_RATE_4X: ips_nxt = `DCC_INSTR_4X;  // see R13
         default:     ips_nxt = `DCC_INSTR_1X;  // see R11, R14
      endcase
      // Debounce length from the field
      case (cc_r[`DCC_B_DEB_HI:`DCC_B_DEB_LO])
         2'b00:   deb_lim = DEB_W'(DEB_C00);  // see R1
         2'b01:   deb_lim = DEB_W'(DEB_C01);  // see R1
         2'b10:   deb_lim = DEB_W'(DEB_C10);  // see R1
         default: deb_lim = DEB_W'(DEB_C11);  // see R1
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Register stage
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cc_r  <= `DCC_CORE_CTRL_RST;  // see R8, R9, R10
         rd_r  <= '0;
         ips_r <= `DCC_INSTR_1X;
         for (int i = 0; i < 8; i++) begin
            if_r[i] <= '0;
         end
         for (int i = 0; i < 4; i++) begin
            ax_r[i] <= '0;
         end
      end else begin
         cc_r  <= cc_nxt;
         rd_r  <= rd_nxt;
         ips_r <= ips_nxt;
         if_r  <= if_nxt;
         ax_r  <= ax_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Per-pin debounce: a level must hold for the whole window
   for (genvar g = 0; g < NGPIO; g++) begin : g_deb
      logic [DEB_W-1:0] cnt_r, cnt_nxt;
      logic             st_r, st_nxt;
      always_comb begin
         cnt_nxt = '0;
         st_nxt  = st_r;
         if (gpio_in[g] != st_r) begin
            if (cnt_r >= deb_lim - DEB_W'(1)) begin
               st_nxt = gpio_in[g];  // see R1
            end else begin
               cnt_nxt = cnt_r + DEB_W'(1);
            end
         end
      end
      always_ff @(posedge sys_clk) begin
         if (rst) begin
            cnt_r <= '0;
            st_r  <= 1'b0;
         end else begin
            cnt_r <= cnt_nxt;
            st_r  <= st_nxt;
         end
      end
      assign gpio_deb[g] = st_r;
   end

   ////////////////////////////////////////////////////////////////////////
   // Safeload engine
   dcc_safeload #(.PA_W(PA_W), .PD_W(REG_W)) u_sl (
      .sys_clk (sys_clk),
      .rst     (rst),
      .sl      (sl)
   );

   ////////////////////////////////////////////////////////////////////////
   // Outputs, all straight from flops
   for (genvar k = 0; k < 8; k++) begin : g_ifo
      assign iface_regs[k*REG_W +: REG_W] = if_r[k];
   end
   for (genvar k = 0; k < 4; k++) begin : g_axo
      assign aux_regs[k*REG_W +: REG_W] = ax_r[k];
   end
   assign ctl_rdata          = rd_r;
   assign pin_reg_host_write = cc_r[`DCC_B_PIN_HW];
   assign input_mute         = ~cc_r[`DCC_B_IN_UNMUTE];   // see R8
   assign output_mute        = ~cc_r[`DCC_B_OUT_UNMUTE];  // see R9
   assign core_clear         = ~cc_r[`DCC_B_CORE_RUN];    // see R10
   assign rate_select        = cc_r[`DCC_B_RATE_HI:`DCC_B_RATE_LO];
   assign instr_per_sample   = ips_r;
   assign pm_we              = sl.pm_we;
   assign pm_addr            = sl.pm_addr;
   assign pm_data            = sl.pm_data;
endmodule
`default_nettype wire

// ---- verification/dcc_core_ctrl_props.sv ----
// Port checker of the core control block
`timescale 1ns/1ns
`default_nettype none
`include "dcc_defines.svh"
module dcc_core_ctrl_props
   import dcc_pkg::*;
#(
   parameter int REG_W = 32
) (
   input wire logic               sys_clk,
   input wire logic               rst,
   input wire logic               ctl_wr,
   input wire logic [11:0]        ctl_addr,
   input wire logic [REG_W-1:0]   ctl_wdata,
   input wire logic               prog_if_we,
   input wire logic               aux_pin_we,
   input wire logic [8*REG_W-1:0] iface_regs,
   input wire logic [4*REG_W-1:0] aux_regs,
   input wire logic               input_mute,
   input wire logic               output_mute,
   input wire logic               core_clear,
   input wire logic [1:0]         rate_select,
   input wire logic [10:0]        instr_per_sample
);
   logic [15:0] sh_r;    // Shadow of the stored control bits
   logic [15:0] sh_nxt;  // Next shadow value
   ////////////////////////////////////////////////////////////////////////
   // Shadow; trigger bit left out since it clears by itself
   always_comb begin
      sh_nxt = sh_r;
      if (ctl_wr && ctl_addr == `DCC_LOC_CORE_CTRL) begin
         sh_nxt = ctl_wdata[15:0] & 16'h31DF;
      end
   end
   always_ff @(posedge sys_clk) begin
      sh_r <= rst ? 16'h0000 : sh_nxt;
   end
   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Code 11 falls back to the single rate count
   AST_RATE_1X: assert property ($stable(rate_select) && rate_select[0] ==
      rate_select[1] |-> instr_per_sample == 11'h400)
      else $error("single rate count wrong");
   AST_RATE_2X: assert property ($stable(rate_select) && rate_select ==
      2'b01 |-> instr_per_sample == 11'h200)
      else $error("double rate count wrong");
   AST_RATE_4X: assert property ($stable(rate_select) && rate_select ==
      2'b10 |-> instr_per_sample == 11'h100)
      else $error("quadruple rate count wrong");
   // Stable over two samples so one register stage is tolerated
   AST_IN_MUTE: assert property ($stable(sh_r[4]) |->
      input_mute == !sh_r[4])
      else $error("input mute not inverse of its bit");
   AST_OUT_MUTE: assert property ($stable(sh_r[3]) |->
      output_mute == !sh_r[3])
      else $error("output mute not inverse of its bit");
   AST_CORE_CLR: assert property ($stable(sh_r[2]) |->
      core_clear == !sh_r[2])
      else $error("core clear not inverse of run bit");
   AST_IF_BLOCK: assert property (sh_r[6] && prog_if_we && !ctl_wr |=>
      $stable(iface_regs))
      else $error("program wrote interface while host owns it");
   AST_IF_REFUSE: assert property (!sh_r[6] && ctl_wr && !prog_if_we &&
      ctl_addr[11:3] == 9'h100 |=> $stable(iface_regs))
      else $error("port wrote interface without permission");
   AST_AUX_BLOCK: assert property (sh_r[8] && aux_pin_we && !ctl_wr |=>
      $stable(aux_regs))
      else $error("pins wrote aux while host owns it");
   AST_AUX_REFUSE: assert property (!sh_r[8] && ctl_wr && !aux_pin_we &&
      ctl_addr inside {[12'h809:12'h80C]} |=> $stable(aux_regs))
      else $error("port wrote aux without permission");
endmodule
bind dcc_core_ctrl dcc_core_ctrl_props #(.REG_W(REG_W)) u_props (
   .sys_clk, .rst, .ctl_wr, .ctl_addr, .ctl_wdata, .prog_if_we,
   .aux_pin_we, .iface_regs, .aux_regs, .input_mute, .output_mute,
   .core_clear, .rate_select, .instr_per_sample);
`default_nettype wire

// ---- verification/dcc_host_model.sv ----
// Host controller model on the control port
`timescale 1ns/1ns
`default_nettype none
module dcc_host_model (
   input  wire logic        sys_clk,
   output var  logic        ctl_wr,
   output var  logic        ctl_rd,
   output var  logic [11:0] ctl_addr,
   output var  logic [31:0] ctl_wdata
);
   // Port idle from time zero
   initial begin
      ctl_wr = 1'b0;
      ctl_rd = 1'b0;
      ctl_addr = 12'h000;
      ctl_wdata = 32'h00000000;
   end
   // One access, held across the sampling edge
   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
      @(negedge sys_clk);
      ctl_wr = w;
      ctl_rd = !w;
      ctl_addr = a;
      ctl_wdata = d;
      @(negedge sys_clk);
      ctl_wr = 1'b0;
      ctl_rd = 1'b0;
      // Released lines show the inverse, never a stale value
      ctl_addr = ~a;
      ctl_wdata = ~d;
   endtask
   // Unmute both sides and run; reserved rate never sent
   task automatic run_core(input logic [1:0] r);
      xfer(1'b1, 12'h81C, {27'h0, 3'h7, (r == 2'h3) ? 2'h0 : r});
   endtask
endmodule
`default_nettype wire

// ---- verification/dcc_core_ctrl_tb.sv ----
// Self-checking bench of the core control block
`timescale 1ns/1ns
`default_nettype none
module dcc_core_ctrl_tb
   import dcc_pkg::*;
;
   logic         sys_clk, rst, ctl_wr, ctl_rd, pm_we, rd_seen;
   logic         prog_if_we, aux_pin_we, pin_reg_host_write;
   logic         input_mute, output_mute, core_clear;
   logic [11:0]  ctl_addr;       // Port location
   logic [31:0]  ctl_wdata, ctl_rdata, prog_if_data, aux_pin_data;
   logic [2:0]   prog_if_idx;
   logic [1:0]   aux_pin_idx, rate_select;
   logic [255:0] iface_regs;     // Eight interface registers
   logic [127:0] aux_regs;       // Four aux registers
   logic [3:0]   gpio_in, gpio_deb;
   logic [10:0]  instr_per_sample;
   logic [9:0]   pm_addr;
   logic [31:0]  pm_data, lfsr_r;
   logic [31:0]  rd_q[$];        // Expected read data
   logic [41:0]  pm_q[$];        // Expected memory writes
   int           n_errors, n_compared;
   int           cnt[4];         // Debounce latencies seen
   int           lims[4] = '{4, 8, 2, 1};
   // Short debounce counts keep the run brief
   dcc_core_ctrl #(.DEB_C00(4), .DEB_C01(8), .DEB_C10(2), .DEB_C11(1)) DUT (
      .sys_clk, .rst, .ctl_wr, .ctl_rd, .ctl_addr, .ctl_wdata, .ctl_rdata,
      .prog_if_we, .prog_if_idx, .prog_if_data, .aux_pin_we, .aux_pin_idx,
      .aux_pin_data, .iface_regs, .aux_regs, .gpio_in, .gpio_deb,
      .pin_reg_host_write, .input_mute, .output_mute, .core_clear,
      .rate_select, .instr_per_sample, .pm_we, .pm_addr, .pm_data);
   dcc_host_model host (.sys_clk, .ctl_wr, .ctl_rd, .ctl_addr, .ctl_wdata);
   ////////////////////////////////////////////////////////////////////////
   // 250 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic chk(input string nm, input logic [63:0] e,
                      input logic [63:0] g);
      n_compared++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Note the expected word before the read goes out
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      rd_q.push_back(e);
      host.xfer(1'b0, a, 32'h00000000);
   endtask
   // Program (s low) or pin (s high) write
   task automatic pin(input logic s, input logic [2:0] i,
                      input logic [31:0] d);
      @(negedge sys_clk);
      prog_if_we = !s;
      aux_pin_we = s;
      prog_if_idx = i;
      aux_pin_idx = i[1:0];
      prog_if_data = d;
      aux_pin_data = d;
      @(negedge sys_clk);
      prog_if_we = 1'b0;
      aux_pin_we = 1'b0;
      prog_if_data = ~d;
      aux_pin_data = ~d;
   endtask
   task automatic settle();
      repeat (2) @(negedge sys_clk);
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Monitor: read data half a cycle after the read edge, memory pulses
   always @(posedge sys_clk) rd_seen <= ctl_rd;
   always @(negedge sys_clk) begin
      if (rd_seen === 1'b1) begin
         chk("read data", rd_q.pop_front(), ctl_rdata);
      end
      if (pm_we === 1'b1) begin
         chk("param write", pm_q.pop_front(), {pm_addr, pm_data});
      end
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      logic [31:0] d;
      logic [31:0] e;
      logic [9:0]  a;
      {rst, prog_if_we, aux_pin_we} = 3'h7;
      {prog_if_idx, aux_pin_idx, gpio_in} = 9'h000;
      {prog_if_data, aux_pin_data} = 64'h0;
      {n_errors, n_compared} = 64'h0;
      lfsr_r = 32'h0000BE44;
      @(negedge sys_clk);
      {prog_if_we, aux_pin_we} = 2'h0;
      repeat (15) @(negedge sys_clk);
      rst = 1'b0;
      rd(12'h81C, 32'h0);
      chk("input mute", 1, input_mute);
      chk("output mute", 1, output_mute);
      chk("core clear", 1, core_clear);
      chk("instr", 11'h400, instr_per_sample);
      $display("test reset done");
      // Reserved bits read zero, rate left at quadruple
      host.xfer(1'b1, 12'h81C, 32'h0000FFDE);
      rd(12'h81C, 32'h000031DE);
      settle();
      chk("muted", 0, {input_mute, output_mute, core_clear});
      for (int r = 0; r < 3; r++) begin
         host.run_core(r[1:0]);
         settle();
         chk("instr", 11'h400 >> r, instr_per_sample);
         chk("rate", r, rate_select);
      end
      rd(12'h900, 32'h0);
      $display("test rates done");
      lfsr_r = lfsr(lfsr_r);
      d = lfsr_r;
      lfsr_r = lfsr(lfsr_r);
      e = lfsr_r;
      // Permission bits clear: port refused, program and pins pass
      host.xfer(1'b1, 12'h803, d);
      host.xfer(1'b1, 12'h80A, d);
      pin(1'b0, 3'h5, e);
      pin(1'b1, 3'h2, e);
      settle();
      chk("iface 3", 0, iface_regs[96+:32]);
      chk("iface 5", e, iface_regs[160+:32]);
      chk("aux 1", 0, aux_regs[32+:32]);
      chk("aux 2", e, aux_regs[64+:32]);
      host.xfer(1'b1, 12'h81C, 32'h000001C0);
      host.xfer(1'b1, 12'h803, d);
      host.xfer(1'b1, 12'h80A, d);
      pin(1'b0, 3'h3, e);
      pin(1'b1, 3'h1, e);
      settle();
      chk("iface 3", d, iface_regs[96+:32]);
      chk("aux 1", d, aux_regs[32+:32]);
      rd(12'h803, d);
      rd(12'h80A, d);
      chk("pin host write", 1, pin_reg_host_write);
      $display("test host write done");
      // First and last pair only
      a = lfsr_r[9:0];
      host.xfer(1'b1, 12'h810, d);
      host.xfer(1'b1, 12'h815, {22'h0, a});
      host.xfer(1'b1, 12'h814, e);
      host.xfer(1'b1, 12'h819, {22'h0, ~a});
      pm_q.push_back({a, d});
      pm_q.push_back({~a, e});
      host.xfer(1'b1, 12'h81C, 32'h00000020);
      repeat (12) @(negedge sys_clk);
      chk("pending", 0, pm_q.size());
      rd(12'h81C, 32'h0);
      // Nothing fresh, so nothing copied
      host.xfer(1'b1, 12'h81C, 32'h00000020);
      repeat (12) @(negedge sys_clk);
      $display("test safeload done");
      for (int c = 0; c < 4; c++) begin
         host.xfer(1'b1, 12'h81C, {18'h0, c[1:0], 12'h0});
         gpio_in = ~gpio_in;
         cnt[c] = 0;
         while (gpio_deb !== gpio_in) begin
            @(negedge sys_clk);
            cnt[c]++;
            if (cnt[c] > 40) begin
               n_errors++;
               summarize();
            end
         end
      end
      // Relative latencies cancel any fixed pipeline offset
      for (int c = 0; c < 3; c++) begin
         chk("debounce", lims[c] - 1, cnt[c] - cnt[3]);
      end
      $display("test debounce done");
      rst = 1'b1;
      repeat (2) @(negedge sys_clk);
      rst = 1'b0;
      rd(12'h81C, 32'h0);
      chk("core clear", 1, core_clear);
      repeat (4) @(negedge sys_clk);
      $display("test second reset done");
      summarize();
   end
endmodule
`default_nettype wire
